/* File: design/gst_phase_div.sv */
// Purpose: Instruction-cycle enable, one pulse every DIV clocks.
// Assumes: halt_i high while the processor sleeps.
// Notes: The pulse is combinational so a halt takes effect at once.
`timescale 1ns/1ps
`default_nettype none
module gst_phase_div #(
	parameter int unsigned DIV = 4
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Control
	input wire logic halt_i,
	output logic tick_o
);
	localparam int unsigned CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;

	always_comb begin
		cnt_next = cnt_reg;
		tick_o = 1'b0;
		if (!halt_i) begin
			tick_o = (cnt_reg == LAST);
			cnt_next = tick_o ? '0 : cnt_reg + CW'(1);
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
endmodule
`default_nettype wire

/* File: design/gst_pkg.sv */
// Purpose: Constants for the gated sixteen-bit timer.
// Assumes: AHB-Lite word per register, byte address = index * 4.
// Notes: Register indices are word indices; the bus uses byte address index * 4.
// Functional notes
// - 16-bit count in two bytes; wrap from ffff to 0000 sets rollover flag.
// - Clock source select picks instruction clock or external clock.
// - Optional external gate input qualifies counting when enabled.
// - Sync disable bit 2 counts external edges without instruction-phase alignment.
// - Unsynchronised counter keeps counting in sleep; rollover can wake.
// - Outside unsynchronised counter mode nothing counts during sleep.
// - Byte reads of the count always return a clean value.
// - Oscillator enable bit 3 runs the crystal amplifier, also in sleep.
// - Oscillator usable only while system clock is internal.
// - Oscillator on forces port A 5/4 direction to 1, pins read 0.
// - Rollover wakes when timer on, rollover enable and peripheral enable set.
// - With global enable also set, wake also branches to the service routine.
package gst_pkg;
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned INSTR_DIV = 4;
	localparam int unsigned PRESC_W = 3;
	localparam int unsigned IDX_W = 10;
	localparam logic [9:0] IDX_INTERRUPT_CONTROL = 10'h00b;
	localparam logic [9:0] IDX_PERIPHERAL_FLAGS = 10'h00c;
	localparam logic [9:0] IDX_COUNT_LOW_BYTE = 10'h00e;
	localparam logic [9:0] IDX_COUNT_HIGH_BYTE = 10'h00f;
	localparam logic [9:0] IDX_TIMER_CONTROL = 10'h010;
	localparam logic [9:0] IDX_PERIPHERAL_ENABLES = 10'h08c;
	localparam logic [9:0] IDX_EVENT_STATUS = 10'h0a0;
	localparam logic [9:0] IDX_EVENT_CLEAR = 10'h0a1;
	localparam logic [9:0] IDX_EVENT_ENABLE = 10'h0a2;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [7:0] TC_MASK = 8'h7f;
	localparam logic [7:0] PE_MASK = 8'h01;
	localparam logic [7:0] EV_MASK = 8'h03;
	localparam int unsigned TC_TIMER_ON = 0;
	localparam int unsigned TC_CLK_SRC = 1;
	localparam int unsigned TC_SYNC_DIS = 2;
	localparam int unsigned TC_OSC_EN = 3;
	localparam int unsigned TC_PRESC_LO = 4;
	localparam int unsigned TC_PRESC_HI = 5;
	localparam int unsigned TC_GATE_EN = 6;
	localparam int unsigned IC_PERIPHERAL_INT_ENABLE = 6;
	localparam int unsigned IC_GIE = 7;
	localparam int unsigned PE_ROLLOVER = 0;
	localparam int unsigned EV_ROLLOVER = 0;
	localparam int unsigned EV_WAKE = 1;
endpackage

/* File: design/gst_prescale.sv */
// Purpose: Divide a tick stream by 1, 2, 4 or 8.
// Assumes: clear_i restarts the division.
// Notes: Output is combinational from the incoming tick.
`timescale 1ns/1ps
`default_nettype none
module gst_prescale #(
	parameter int unsigned W = 3
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// Ticks
	input wire logic clear_i,
	input wire logic tick_i,
	input wire logic [1:0] sel_i,
	output logic tick_o
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;

	function automatic logic [W-1:0] low_mask(input logic [1:0] sel);
		low_mask = (W'(1) << sel) - W'(1);
	endfunction

	always_comb begin
		tick_o = tick_i && ((cnt_reg & low_mask(sel_i)) == low_mask(sel_i));
		cnt_next = cnt_reg;
		if (clear_i) begin
			cnt_next = '0;
		end else if (tick_i) begin
			cnt_next = cnt_reg + W'(1);
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
endmodule
`default_nettype wire

/* File: design/gst_timer.sv */
// Purpose: Gated sixteen-bit timer with AHB-Lite register slave.
// Assumes: External pins already synchronous to clock_i.
// Notes: Zero wait state slave; read data is sampled in the address phase.
`timescale 1ns/1ps
`default_nettype none
module gst_timer (
	// Clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [11:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Clock sources and gate
	input wire logic ext_clk_i,
	input wire logic gate_input_i,
	input wire logic osc_in_pin_i,
	output logic osc_out_pin_o,
	input wire logic sys_clk_internal_i,
	input wire logic sleep_i,
	// Port A pins 5 and 4, bit 1 is pin 5
	input wire logic [1:0] port_a_dir_i,
	input wire logic [1:0] port_a_pin_i,
	output logic [1:0] port_a_dir_o,
	output logic [1:0] port_a_read_o,
	// Wake and interrupt
	output logic wake_o,
	output logic isr_o,
	output logic irq_o
);
	logic wr_pend_reg, wr_pend_next;
	logic [9:0] wr_idx_reg, wr_idx_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic addr_ok;
	logic [7:0] wdat;
	logic [15:0] count_reg, count_next;
	logic [7:0] tc_reg, tc_next;
	logic [7:0] ic_reg, ic_next;
	logic [7:0] pe_reg, pe_next;
	logic [7:0] evs_reg, evs_next;
	logic [7:0] eve_reg, eve_next;
	logic flag_reg, flag_next;
	logic ext_prev_reg, ext_prev_next;
	logic pend_reg, pend_next;
	logic osc_reg, osc_next;
	logic [1:0] pdir_reg, pdir_next;
	logic [1:0] pread_reg, pread_next;
	logic wake_reg, wake_next;
	logic isr_reg, isr_next;
	logic irq_reg, irq_next;
	logic phase_tick, presc_tick, raw_tick, count_en, presc_clr;
	logic async_mode, osc_ok, ext_level, ext_rise, rollover_evt, wake_cond;
	logic [7:0] evts;

	function automatic logic is_wr(input logic pend, input logic [9:0] idx,
			input logic [9:0] want);
		is_wr = pend && (idx == want);
	endfunction

	function automatic logic [7:0] read_mux(input logic [9:0] idx);
		unique case (idx)
			gst_pkg::IDX_INTERRUPT_CONTROL: read_mux = ic_reg;
			gst_pkg::IDX_PERIPHERAL_FLAGS: read_mux = {7'h00, flag_reg};
			gst_pkg::IDX_COUNT_LOW_BYTE: read_mux = count_reg[7:0];
			gst_pkg::IDX_COUNT_HIGH_BYTE: read_mux = count_reg[15:8];
			gst_pkg::IDX_TIMER_CONTROL: read_mux = tc_reg;
			gst_pkg::IDX_PERIPHERAL_ENABLES: read_mux = pe_reg;
			gst_pkg::IDX_EVENT_STATUS: read_mux = evs_reg;
			gst_pkg::IDX_EVENT_ENABLE: read_mux = eve_reg;
			default: read_mux = gst_pkg::RST_BYTE;
		endcase
	endfunction

	// Halting the phase clock in sleep stops internal and synchronised counting
	gst_phase_div #(
		.DIV(gst_pkg::INSTR_DIV)
	) u_div (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.halt_i(sleep_i),
		.tick_o(phase_tick)
	);

	gst_prescale #(
		.W(gst_pkg::PRESC_W)
	) u_presc (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.clear_i(presc_clr),
		.tick_i(raw_tick & count_en),
		.sel_i({tc_reg[gst_pkg::TC_PRESC_HI], tc_reg[gst_pkg::TC_PRESC_LO]}),
		.tick_o(presc_tick)
	);

	// Bus slave
	always_comb begin
		addr_ok = hsel_i && hready_i && htrans_i[1];
		wr_pend_next = addr_ok && hwrite_i;
		wr_idx_next = addr_ok ? haddr_i[11:2] : wr_idx_reg;
		hrdata_next = '0;
		if (addr_ok && !hwrite_i) begin
			hrdata_next = {24'h000000, read_mux(haddr_i[11:2])};
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg <= '0;
			hrdata_reg <= '0;
		end else begin
			wr_pend_reg <= wr_pend_next;
			wr_idx_reg <= wr_idx_next;
			hrdata_reg <= hrdata_next;
		end
	end

	// Timer core
	always_comb begin
		wdat = hwdata_i[7:0];
		async_mode = tc_reg[gst_pkg::TC_CLK_SRC] && tc_reg[gst_pkg::TC_SYNC_DIS];
		osc_ok = tc_reg[gst_pkg::TC_OSC_EN] && sys_clk_internal_i;
		ext_level = osc_ok ? osc_in_pin_i : ext_clk_i;
		ext_rise = ext_level && !ext_prev_reg;
		ext_prev_next = ext_level;
		// Synchronised mode takes at most one edge per instruction cycle
		pend_next = (ext_rise && !async_mode) || (pend_reg && !phase_tick);
		if (!tc_reg[gst_pkg::TC_CLK_SRC]) begin
			raw_tick = phase_tick;
		end else if (tc_reg[gst_pkg::TC_SYNC_DIS]) begin
			raw_tick = ext_rise;
		end else begin
			raw_tick = pend_reg && phase_tick;
		end
		count_en = tc_reg[gst_pkg::TC_TIMER_ON] &&
			(!tc_reg[gst_pkg::TC_GATE_EN] || !gate_input_i);
		presc_clr = is_wr(wr_pend_reg, wr_idx_reg, gst_pkg::IDX_COUNT_LOW_BYTE) ||
			is_wr(wr_pend_reg, wr_idx_reg, gst_pkg::IDX_COUNT_HIGH_BYTE) ||
			is_wr(wr_pend_reg, wr_idx_reg, gst_pkg::IDX_TIMER_CONTROL);
		rollover_evt = presc_tick && (count_reg == gst_pkg::COUNT_MAX);
		count_next = presc_tick ? count_reg + gst_pkg::COUNT_ONE : count_reg;
		// A colliding write wins over the increment
		if (is_wr(wr_pend_reg, wr_idx_reg, gst_pkg::IDX_COUNT_LOW_BYTE)) begin
			count_next[7:0] = wdat;
		end
		if (is_wr(wr_pend_reg, wr_idx_reg, gst_pkg::IDX_COUNT_HIGH_BYTE)) begin
			count_next[15:8] = wdat;
		end
		tc_next = tc_reg;
		if (is_wr(wr_pend_reg, wr_idx_reg, gst_pkg::IDX_TIMER_CONTROL)) begin
			tc_next = wdat & gst_pkg::TC_MASK;
		end
		ic_next = ic_reg;
		if (is_wr(wr_pend_reg, wr_idx_reg, gst_pkg::IDX_INTERRUPT_CONTROL)) begin
			ic_next = wdat;
		end
		pe_next = pe_reg;
		if (is_wr(wr_pend_reg, wr_idx_reg, gst_pkg::IDX_PERIPHERAL_ENABLES)) begin
			pe_next = wdat & gst_pkg::PE_MASK;
		end
		eve_next = eve_reg;
		if (is_wr(wr_pend_reg, wr_idx_reg, gst_pkg::IDX_EVENT_ENABLE)) begin
			eve_next = wdat & gst_pkg::EV_MASK;
		end
		flag_next = flag_reg;
		if (is_wr(wr_pend_reg, wr_idx_reg, gst_pkg::IDX_PERIPHERAL_FLAGS) && !wdat[0]) begin
			flag_next = 1'b0;
		end
		flag_next = flag_next || rollover_evt;
		wake_cond = sleep_i && flag_reg && pe_reg[gst_pkg::PE_ROLLOVER] &&
			ic_reg[gst_pkg::IC_PERIPHERAL_INT_ENABLE] && tc_reg[gst_pkg::TC_TIMER_ON];
		evts = '0;
		evts[gst_pkg::EV_ROLLOVER] = rollover_evt;
		evts[gst_pkg::EV_WAKE] = wake_cond && !wake_reg;
		evs_next = evs_reg;
		if (is_wr(wr_pend_reg, wr_idx_reg, gst_pkg::IDX_EVENT_CLEAR)) begin
			evs_next = evs_reg & ~wdat;
		end
		evs_next = evs_next | evts;
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			count_reg <= gst_pkg::RST_COUNT;
			tc_reg <= gst_pkg::RST_BYTE;
			ic_reg <= gst_pkg::RST_BYTE;
			pe_reg <= gst_pkg::RST_BYTE;
			evs_reg <= gst_pkg::RST_BYTE;
			eve_reg <= gst_pkg::RST_BYTE;
			flag_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
			pend_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			tc_reg <= tc_next;
			ic_reg <= ic_next;
			pe_reg <= pe_next;
			evs_reg <= evs_next;
			eve_reg <= eve_next;
			flag_reg <= flag_next;
			ext_prev_reg <= ext_prev_next;
			pend_reg <= pend_next;
		end
	end

	// Pins and wake outputs
	always_comb begin
		osc_next = osc_ok && !osc_in_pin_i;
		pdir_next = tc_reg[gst_pkg::TC_OSC_EN] ? 2'h3 : port_a_dir_i;
		pread_next = tc_reg[gst_pkg::TC_OSC_EN] ? 2'h0 : port_a_pin_i;
		wake_next = wake_cond;
		isr_next = wake_cond && ic_reg[gst_pkg::IC_GIE];
		irq_next = |(evs_reg & eve_reg);
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			osc_reg <= 1'b0;
			pdir_reg <= 2'h3;
			pread_reg <= 2'h0;
			wake_reg <= 1'b0;
			isr_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			osc_reg <= osc_next;
			pdir_reg <= pdir_next;
			pread_reg <= pread_next;
			wake_reg <= wake_next;
			isr_reg <= isr_next;
			irq_reg <= irq_next;
		end
	end

	assign hrdata_o = hrdata_reg;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign osc_out_pin_o = osc_reg;
	assign port_a_dir_o = pdir_reg;
	assign port_a_read_o = pread_reg;
	assign wake_o = wake_reg;
	assign isr_o = isr_reg;
	assign irq_o = irq_reg;

	logic any_cnt_wr;
	assign any_cnt_wr = is_wr(wr_pend_reg, wr_idx_reg, gst_pkg::IDX_COUNT_LOW_BYTE) ||
		is_wr(wr_pend_reg, wr_idx_reg, gst_pkg::IDX_COUNT_HIGH_BYTE);

	sequence s_wrap;
		presc_tick && count_reg == gst_pkg::COUNT_MAX && !any_cnt_wr;
	endsequence
	sequence s_zero_flag;
		count_reg == gst_pkg::RST_COUNT && flag_reg;
	endsequence
	property p_wrap;
		@(posedge clock_i) disable iff (sys_rst_i)
		s_wrap |=> s_zero_flag;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap did not zero and flag");

	property p_internal;
		@(posedge clock_i) disable iff (sys_rst_i)
		!tc_reg[gst_pkg::TC_CLK_SRC] && count_en &&
			tc_reg[gst_pkg::TC_PRESC_HI:gst_pkg::TC_PRESC_LO] == 2'h0 |->
			presc_tick == phase_tick;
	endproperty
	a_internal: assert property (p_internal) else $error("tick without source");

	property p_gate;
		@(posedge clock_i) disable iff (sys_rst_i)
		tc_reg[gst_pkg::TC_GATE_EN] && gate_input_i && !any_cnt_wr |=>
			$stable(count_reg);
	endproperty
	a_gate: assert property (p_gate) else $error("counted with gate closed");

	property p_async;
		@(posedge clock_i) disable iff (sys_rst_i)
		async_mode && ext_rise && count_en && !presc_clr &&
			tc_reg[gst_pkg::TC_PRESC_HI:gst_pkg::TC_PRESC_LO] == 2'h0 &&
			count_reg != gst_pkg::COUNT_MAX |=>
			count_reg == $past(count_reg) + gst_pkg::COUNT_ONE;
	endproperty
	a_async: assert property (p_async) else $error("async edge not counted");

	property p_sleep;
		@(posedge clock_i) disable iff (sys_rst_i)
		sleep_i && !async_mode && !any_cnt_wr |=> $stable(count_reg);
	endproperty
	a_sleep: assert property (p_sleep) else $error("counted in sleep");

	property p_read;
		@(posedge clock_i) disable iff (sys_rst_i)
		addr_ok && !hwrite_i && haddr_i[11:2] == gst_pkg::IDX_COUNT_LOW_BYTE |=>
			hrdata_o == {24'h000000, $past(count_reg[7:0])};
	endproperty
	a_read: assert property (p_read) else $error("bad count read");

	property p_osc;
		@(posedge clock_i) disable iff (sys_rst_i)
		1'b1 |=> osc_out_pin_o == ($past(osc_ok) && !$past(osc_in_pin_i));
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator drive wrong");

	property p_pins;
		@(posedge clock_i) disable iff (sys_rst_i)
		tc_reg[gst_pkg::TC_OSC_EN] |=> port_a_dir_o == 2'h3 && port_a_read_o == 2'h0;
	endproperty
	a_pins: assert property (p_pins) else $error("port pins not forced");

	property p_wake;
		@(posedge clock_i) disable iff (sys_rst_i)
		wake_cond |=> wake_o ##0 (isr_o == $past(ic_reg[gst_pkg::IC_GIE]));
	endproperty
	a_wake: assert property (p_wake) else $error("wake or branch wrong");

	property p_flag_hold;
		@(posedge clock_i) disable iff (sys_rst_i)
		flag_reg && !is_wr(wr_pend_reg, wr_idx_reg, gst_pkg::IDX_PERIPHERAL_FLAGS) |=>
			flag_reg;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

	property p_presc;
		@(posedge clock_i) disable iff (sys_rst_i)
		presc_tick |-> raw_tick && count_en;
	endproperty
	a_presc: assert property (p_presc) else $error("prescaler ticked alone");
endmodule
`default_nettype wire

/* File: test/gst_clk_src.sv */
// Purpose: Far-side clock source, an external clock or a watch crystal.
// Assumes: run_i and half_i change just after a rising edge of clock_i.
// Notes: Output rests low while stopped, so no stale level looks like an edge.
`timescale 1ns/1ps
`default_nettype none
module gst_clk_src (
	// Clock
	input wire logic clock_i,
	// Control
	input wire logic run_i,
	input wire logic [3:0] half_i,
	// Source output
	output logic clk_o
);
	logic [3:0] cnt;
	initial begin
		cnt = 4'h0;
		clk_o = 1'b0;
	end
	always @(posedge clock_i) begin
		if (!run_i) begin
			cnt <= 4'h0;
			clk_o <= 1'b0;
		end else if (cnt >= half_i) begin
			cnt <= 4'h0;
			clk_o <= ~clk_o;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule
`default_nettype wire

/* File: test/gst_timer_tb.sv */
// Purpose: Self-checking bench for the gated sixteen-bit timer.
// Assumes: Zero wait state slave; hready is fed back from hreadyout.
// Notes: Internal counts allow one tick of slack for the free-running phase.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module gst_timer_tb;
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic hsel = 1'b0, hwrite = 1'b0, gate = 1'b0, sys_int = 1'b1, sleep = 1'b0;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'b00, dir_i = 2'b00, pin_i = 2'b00;
	logic [31:0] hwdata = 32'h0, hrdata;
	logic hreadyout, hresp, ext_clk, osc_out, wake, isr, irq;
	logic osc_in = 1'b0;
	logic [1:0] dir_o, read_o;
	logic run_e = 1'b0, ext_q = 1'b0;
	logic [3:0] half = 4'h7;
	logic [7:0] b, bh;
	logic [15:0] c;
	int n_fail = 0, total_checks = 0, n_edge = 0, cyc = 0, seed = 32'hdaf31e06;
	int e, t0;
	logic [9:0] idx[9] = '{gst_pkg::IDX_INTERRUPT_CONTROL, gst_pkg::IDX_PERIPHERAL_FLAGS,
		gst_pkg::IDX_COUNT_LOW_BYTE, gst_pkg::IDX_COUNT_HIGH_BYTE, gst_pkg::IDX_TIMER_CONTROL,
		gst_pkg::IDX_PERIPHERAL_ENABLES, gst_pkg::IDX_EVENT_STATUS, gst_pkg::IDX_EVENT_ENABLE,
		10'h3ff};
	always #50 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		cyc++;
		ext_q <= ext_clk;
		if (ext_clk && !ext_q) n_edge++;
	end
	gst_clk_src i_gst_clk_src (.clock_i(clock_i), .run_i(run_e), .half_i(half), .clk_o(ext_clk));
	gst_timer i_gst_timer (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
		.hready_i(hreadyout), .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
		.hresp_o(hresp), .ext_clk_i(ext_clk), .gate_input_i(gate), .osc_in_pin_i(osc_in),
		.osc_out_pin_o(osc_out), .sys_clk_internal_i(sys_int), .sleep_i(sleep),
		.port_a_dir_i(dir_i), .port_a_pin_i(pin_i), .port_a_dir_o(dir_o),
		.port_a_read_o(read_o), .wake_o(wake), .isr_o(isr), .irq_o(irq));
	task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] d,
		output logic [7:0] q);
		hsel <= 1'b1;
		haddr <= {i, 2'b00};
		hwrite <= w;
		htrans <= 2'b10;
		@(posedge clock_i);
		while (hreadyout !== 1'b1) @(posedge clock_i);
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		@(posedge clock_i);
		while (hreadyout !== 1'b1) @(posedge clock_i);
		q = hrdata[7:0];
	endtask
	task automatic wr(input logic [9:0] i, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, i, d, q);
	endtask
	task automatic rd(input logic [9:0] i, output logic [7:0] q);
		bus(1'b0, i, 8'h00, q);
	endtask
	task automatic cnt_rd(output logic [15:0] v);
		logic [7:0] lo, hi;
		rd(gst_pkg::IDX_COUNT_LOW_BYTE, lo);
		rd(gst_pkg::IDX_COUNT_HIGH_BYTE, hi);
		v = {hi, lo};
	endtask
	task automatic restart(input logic [7:0] tc, input logic [15:0] v);
		wr(gst_pkg::IDX_TIMER_CONTROL, 8'h00);
		wr(gst_pkg::IDX_COUNT_LOW_BYTE, v[7:0]);
		wr(gst_pkg::IDX_COUNT_HIGH_BYTE, v[15:8]);
		wr(gst_pkg::IDX_TIMER_CONTROL, tc);
	endtask
	task automatic run_edges(input int n);
		int s;
		s = n_edge;
		run_e <= 1'b1;
		while (n_edge < s + n) @(posedge clock_i);
		run_e <= 1'b0;
		repeat (12) @(posedge clock_i);
		e = n_edge - s;
	endtask
	task automatic tdone(input string nm);
		$display("test %s done", nm);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clock_i);
		n_fail++;
		wrap_up();
	end
	initial begin
		repeat (4) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		@(posedge clock_i);
		foreach (idx[k]) begin
			rd(idx[k], b);
			`CHK("reset value", 8'h00, b)
		end
		tdone("reset");
		bh = $random(seed);
		wr(gst_pkg::IDX_COUNT_LOW_BYTE, bh);
		wr(gst_pkg::IDX_COUNT_HIGH_BYTE, ~bh);
		cnt_rd(c);
		`CHK("count bytes", {~bh, bh}, c)
		wr(gst_pkg::IDX_TIMER_CONTROL, 8'hff);
		rd(gst_pkg::IDX_TIMER_CONTROL, b);
		`CHK("timer_control", 8'h7f, b)
		tdone("holding");
		// Internal source: one step per instruction cycle, divided by 1, 2, 4, 8
		for (int p = 0; p < 4; p++) begin
			restart({2'b00, p[1:0], 4'h1}, 16'h0000);
			t0 = cyc;
			repeat (400) @(posedge clock_i);
			e = (cyc - t0) / (4 << p);
			wr(gst_pkg::IDX_TIMER_CONTROL, 8'h00);
			cnt_rd(c);
			`CHK("prescaled count", 1'b1, (int'(c) + 1 >= e) && (int'(c) <= e + 1))
		end
		tdone("prescale");
		gate <= 1'b1;
		restart(8'h41, 16'h0000);
		repeat (100) @(posedge clock_i);
		cnt_rd(c);
		`CHK("gated count", 16'h0000, c)
		gate <= 1'b0;
		repeat (100) @(posedge clock_i);
		cnt_rd(c);
		`CHK("gate open", 1'b1, c > 16'h0010)
		tdone("gate");
		restart(8'h03, 16'h0000);
		run_edges(20);
		cnt_rd(c);
		`CHK("sync external", e[15:0], c)
		sleep <= 1'b1;
		restart(8'h03, 16'h0000);
		run_edges(10);
		cnt_rd(c);
		`CHK("sync asleep", 16'h0000, c)
		restart(8'h07, 16'h0000);
		run_edges(10);
		cnt_rd(c);
		`CHK("async asleep", e[15:0], c)
		tdone("external");
		for (int g = 0; g < 2; g++) begin
			sleep <= 1'b0;
			wr(gst_pkg::IDX_PERIPHERAL_FLAGS, 8'h00);
			wr(gst_pkg::IDX_EVENT_CLEAR, 8'h03);
			wr(gst_pkg::IDX_PERIPHERAL_ENABLES, 8'h01);
			wr(gst_pkg::IDX_INTERRUPT_CONTROL, g ? 8'hc0 : 8'h40);
			restart(8'h07, 16'hfffe);
			sleep <= 1'b1;
			run_edges(3);
			`CHK("wake", 1'b1, wake)
			`CHK("branch", g[0], isr)
			rd(gst_pkg::IDX_PERIPHERAL_FLAGS, b);
			`CHK("rollover flag", 1'b1, b[0])
			rd(gst_pkg::IDX_EVENT_STATUS, b);
			`CHK("wrap events", 8'h03, b)
			cnt_rd(c);
			`CHK("after wrap", e[15:0] - 16'h0002, c)
			wr(gst_pkg::IDX_COUNT_LOW_BYTE, 8'h00);
			rd(gst_pkg::IDX_PERIPHERAL_FLAGS, b);
			`CHK("flag kept", 1'b1, b[0])
		end
		wr(gst_pkg::IDX_EVENT_ENABLE, 8'h00);
		repeat (2) @(posedge clock_i);
		`CHK("irq masked", 1'b0, irq)
		wr(gst_pkg::IDX_EVENT_ENABLE, 8'h01);
		repeat (2) @(posedge clock_i);
		`CHK("irq raised", 1'b1, irq)
		wr(gst_pkg::IDX_EVENT_CLEAR, 8'h03);
		repeat (2) @(posedge clock_i);
		`CHK("irq cleared", 1'b0, irq)
		wr(gst_pkg::IDX_PERIPHERAL_FLAGS, 8'h00);
		rd(gst_pkg::IDX_PERIPHERAL_FLAGS, b);
		`CHK("flag cleared", 1'b0, b[0])
		tdone("rollover");
		sleep <= 1'b0;
		dir_i <= 2'b00;
		pin_i <= 2'b11;
		wr(gst_pkg::IDX_TIMER_CONTROL, 8'h08);
		repeat (3) @(posedge clock_i);
		`CHK("forced direction", 2'b11, dir_o)
		`CHK("forced pins", 2'b00, read_o)
		`CHK("amplifier", ~osc_in, osc_out)
		wr(gst_pkg::IDX_COUNT_LOW_BYTE, 8'h00);
		wr(gst_pkg::IDX_COUNT_HIGH_BYTE, 8'h00);
		repeat (20) @(posedge clock_i);
		wr(gst_pkg::IDX_TIMER_CONTROL, 8'h0f);
		repeat (5) begin
			osc_in <= 1'b1;
			repeat (4) @(posedge clock_i);
			`CHK("amplifier high", 1'b0, osc_out)
			osc_in <= 1'b0;
			repeat (4) @(posedge clock_i);
		end
		cnt_rd(c);
		`CHK("crystal count", 16'h0005, c)
		sys_int <= 1'b0;
		osc_in <= 1'b1;
		repeat (4) @(posedge clock_i);
		`CHK("shared oscillator", 1'b0, osc_out)
		osc_in <= 1'b0;
		sys_int <= 1'b1;
		cnt_rd(c);
		`CHK("shared count", 16'h0005, c)
		wr(gst_pkg::IDX_TIMER_CONTROL, 8'h00);
		pin_i <= $random(seed);
		repeat (3) @(posedge clock_i);
		`CHK("pins free", pin_i, read_o)
		`CHK("direction free", dir_i, dir_o)
		tdone("oscillator");
		wrap_up();
	end
endmodule
`default_nettype wire
